// [levf_flag.sv]
// one sticky event flag with read clear, set winning over clear
`timescale 1ns/1ps
`default_nettype none
module levf_flag (
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    input  wire logic ce_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    // a set in the clearing cycle survives so the next read sees it
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            flag_o <= 1'b0;
        end else if (ce_i) begin
            if (set_i) begin
                flag_o <= 1'b1;
            end else if (clr_i) begin
                flag_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [levf_monitor.sv]
// checker: read data, tally and interrupt request relations of the line event flag block
`timescale 1ns/1ps
`default_nettype none
module levf_monitor (
    input wire logic                        clk_sys_i,
    input wire logic                        srst_i,
    input wire logic                        ce_i,
    input wire logic [levf_pkg::ADDR_W-1:0] addr_i,
    input wire logic [levf_pkg::DATA_W-1:0] wdata_i,
    input wire logic                        wr_i,
    input wire logic                        rd_i,
    input wire levf_pkg::levf_live_s        live_i,
    input wire levf_pkg::levf_evt_s         evt_i,
    input wire logic [15:0]                 tally_i,
    input wire logic [levf_pkg::DATA_W-1:0] rdata_o,
    input wire logic                        irq_o
);
    logic [4:0] mask_a_ff;
    logic [7:0] mask_b_ff;
    logic       all_masked;
    ////////////////////////////////////////////////////////////////////////////////
    // shadow masks: we must know when no source may reach the request
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mask_a_ff <= levf_pkg::RST_MASK_A;
        end else if (ce_i && wr_i && addr_i == levf_pkg::ADDR_MASK_A) begin
            mask_a_ff <= wdata_i[4:0];
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mask_b_ff <= levf_pkg::RST_MASK_B;
        end else if (ce_i && wr_i && addr_i == levf_pkg::ADDR_MASK_B) begin
            mask_b_ff <= wdata_i;
        end
    end
    assign all_masked = (mask_a_ff == 5'h1F) && (mask_b_ff == 8'hFF);
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    a_rdata_idle_zero: assert property (ce_i && !rd_i |=> rdata_o == 8'h00) else $error("read data not zero");
    a_unmapped_read: assert property (ce_i && rd_i && (addr_i < 8'h14 || addr_i > 8'h1C || addr_i == 8'h18)
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    a_flags_a_reserved: assert property (ce_i && rd_i && addr_i == 8'h19 |=> rdata_o[7:5] == 3'h0)
        else $error("reserved flag bits set");
    a_tally_low_byte: assert property ((ce_i && $stable(tally_i))[*5] ##0 (rd_i && addr_i == 8'h1B)
        |=> rdata_o == $past(tally_i[7:0])) else $error("tally low byte wrong");
    a_tally_high_byte: assert property ((ce_i && $stable(tally_i))[*5] ##0 (rd_i && addr_i == 8'h1B)
        ##1 (!rd_i && $stable(tally_i)) ##1 (rd_i && addr_i == 8'h1C && $stable(tally_i))
        |=> rdata_o == $past(tally_i[15:8])) else $error("tally high byte wrong");
    a_irq_all_masked: assert property ((ce_i && all_masked)[*2] |-> !irq_o) else $error("masked request");
    a_irq_rise_unmask: assert property ($rose(irq_o) |-> $past(all_masked) == 1'b0)
        else $error("request rose while all masked");
    a_read_clears_irq: assert property (
        (ce_i && $stable(live_i) && $stable(evt_i))[*6] ##0 (rd_i && addr_i == 8'h19)
        ##1 ($stable(live_i) && $stable(evt_i)) ##1 (rd_i && addr_i == 8'h1A && $stable(live_i) && $stable(evt_i))
        ##1 ($stable(live_i) && $stable(evt_i)) |=> !irq_o) else $error("request kept after clearing reads");
endmodule
bind levf_top levf_monitor u_mon (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .live_i(live_i), .evt_i(evt_i), .tally_i(tally_i),
    .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// [levf_pkg.sv]
// package: register map, field layout and carrier types for the line event flag block
package levf_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_A  = 5;
    localparam int unsigned NUM_B  = 8;

    localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL = 8'h16;
    localparam logic [ADDR_W-1:0] ADDR_MASK_A   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_MASK_B   = 8'h15;
    localparam logic [ADDR_W-1:0] ADDR_LIVE     = 8'h17;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_A  = 8'h19;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_B  = 8'h1A;
    localparam logic [ADDR_W-1:0] ADDR_TALLY_LO = 8'h1B;
    localparam logic [ADDR_W-1:0] ADDR_TALLY_HI = 8'h1C;

    localparam logic [NUM_A-1:0]  RST_EDGE_SEL  = 5'h00;
    localparam logic [NUM_A-1:0]  RST_MASK_A    = 5'h1F;
    localparam logic [NUM_B-1:0]  RST_MASK_B    = 8'hFF;
    localparam logic [DATA_W-1:0] RST_DATA      = 8'h00;
    localparam logic [15:0]       RST_TALLY     = 16'h0000;

    // live status bits feeding flags a, bit positions as in the register
    typedef struct packed {
        logic pattern_sync;
        logic tx_clock_missing;
        logic driver_short;
        logic alarm_indication;
        logic input_absent;
    } levf_live_s;

    // one-cycle event pulses feeding flags b
    typedef struct packed {
        logic pulse_amplitude_overflow;
        logic jitter_buffer_over;
        logic jitter_buffer_under;
        logic pattern_mismatch;
        logic excess_zero;
        logic code_violation;
        logic one_second_expiry;
        logic tally_overflow;
    } levf_evt_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } levf_bus_s;
endpackage

// [levf_top.sv]
// top: event flags, masks, edge select, error tally registers and interrupt request
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module levf_top (
    input  wire logic                           clk_sys_i,
    input  wire logic                           srst_i,
    input  wire logic                           ce_i,
    input  wire logic [levf_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [levf_pkg::DATA_W-1:0]    wdata_i,
    input  wire logic                           wr_i,
    input  wire logic                           rd_i,
    input  wire levf_pkg::levf_live_s           live_i,
    input  wire levf_pkg::levf_evt_s            evt_i,
    input  wire logic [15:0]                    tally_i,
    output logic [levf_pkg::DATA_W-1:0]         rdata_o,
    output logic                                irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // register state
    levf_pkg::levf_bus_s               bus;
    logic [levf_pkg::NUM_A-1:0]        edge_sel_ff;
    logic [levf_pkg::NUM_A-1:0]        mask_a_ff;
    logic [levf_pkg::NUM_B-1:0]        mask_b_ff;
    logic [levf_pkg::NUM_A-1:0]        live_s1_ff;
    logic [levf_pkg::NUM_A-1:0]        live_s2_ff;
    logic [levf_pkg::NUM_A-1:0]        live_old_ff;
    logic [levf_pkg::NUM_B-1:0]        evt_s1_ff;
    logic [levf_pkg::NUM_B-1:0]        evt_s2_ff;
    logic [levf_pkg::NUM_B-1:0]        evt_old_ff;
    logic [15:0]                       tally_s1_ff;
    logic [15:0]                       tally_s2_ff;
    logic [15:0]                       tally_s3_ff;
    logic [15:0]                       tally_ff;
    logic [7:0]                        tally_hi_hold_ff;
    logic [levf_pkg::NUM_A-1:0]        set_a;
    logic [levf_pkg::NUM_B-1:0]        set_b;
    logic [levf_pkg::NUM_A-1:0]        flags_a;
    logic [levf_pkg::NUM_B-1:0]        flags_b;
    logic                              clr_a;
    logic                              clr_b;
    logic [levf_pkg::DATA_W-1:0]       nxt_rdata;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    ////////////////////////////////////////////////////////////////////////////
    // detectors sit in other clock regions, so their lines pass two flops
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            live_s1_ff  <= '0;
            live_s2_ff  <= '0;
            live_old_ff <= '0;
            evt_s1_ff   <= '0;
            evt_s2_ff   <= '0;
            evt_old_ff  <= '0;
            tally_s1_ff <= levf_pkg::RST_TALLY;
            tally_s2_ff <= levf_pkg::RST_TALLY;
        end else if (ce_i) begin
            live_s1_ff  <= live_i;
            live_s2_ff  <= live_s1_ff;
            live_old_ff <= live_s2_ff;
            evt_s1_ff   <= evt_i;
            evt_s2_ff   <= evt_s1_ff;
            evt_old_ff  <= evt_s2_ff;
            tally_s1_ff <= tally_i;
            tally_s2_ff <= tally_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // the tally word crosses bit by bit, so a value is taken only when two
    // successive synced samples agree; a counter caught mid-carry is skipped
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tally_s3_ff <= levf_pkg::RST_TALLY;
            tally_ff    <= levf_pkg::RST_TALLY;
        end else if (ce_i) begin
            tally_s3_ff <= tally_s2_ff;
            if (tally_s2_ff == tally_s3_ff) begin
                tally_ff <= tally_s3_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rising edge always; falling edge too where edge select is one
    // event inputs are treated as levels and caught on their rise, so a long pulse counts once
    assign set_a = (live_s2_ff & ~live_old_ff) | (edge_sel_ff & ~live_s2_ff & live_old_ff);
    assign set_b = evt_s2_ff & ~evt_old_ff;

    // clearing reads of the two status registers
    assign clr_a = bus.rd && (bus.addr == levf_pkg::ADDR_FLAGS_A);
    assign clr_b = bus.rd && (bus.addr == levf_pkg::ADDR_FLAGS_B);

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags
    for (genvar i = 0; i < levf_pkg::NUM_A; i++) begin : g_flag_a
        levf_flag u_flag (
            .clk_sys_i (clk_sys_i),
            .srst_i    (srst_i),
            .ce_i      (ce_i),
            .set_i     (set_a[i]),
            .clr_i     (clr_a),
            .flag_o    (flags_a[i])
        );
    end

    for (genvar j = 0; j < levf_pkg::NUM_B; j++) begin : g_flag_b
        levf_flag u_flag (
            .clk_sys_i (clk_sys_i),
            .srst_i    (srst_i),
            .ce_i      (ce_i),
            .set_i     (set_b[j]),
            .clr_i     (clr_b),
            .flag_o    (flags_b[j])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable control registers: edge select and both masks
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            edge_sel_ff <= levf_pkg::RST_EDGE_SEL;
            mask_a_ff   <= levf_pkg::RST_MASK_A;
            mask_b_ff   <= levf_pkg::RST_MASK_B;
        end else if (ce_i && bus.wr) begin
            case (bus.addr)
                levf_pkg::ADDR_EDGE_SEL: edge_sel_ff <= bus.wdata[levf_pkg::NUM_A-1:0];
                levf_pkg::ADDR_MASK_A:   mask_a_ff   <= bus.wdata[levf_pkg::NUM_A-1:0];
                levf_pkg::ADDR_MASK_B:   mask_b_ff   <= bus.wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reading the low byte freezes the high byte so the 16-bit pair is coherent
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tally_hi_hold_ff <= levf_pkg::RST_DATA;
        end else if (ce_i && bus.rd && bus.addr == levf_pkg::ADDR_TALLY_LO) begin
            tally_hi_hold_ff <= tally_ff[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; the value returned is the flag state before the clear
    always_comb begin
        nxt_rdata = levf_pkg::RST_DATA;
        case (bus.addr)
            levf_pkg::ADDR_EDGE_SEL: nxt_rdata = {3'h0, edge_sel_ff};
            levf_pkg::ADDR_MASK_A:   nxt_rdata = {3'h0, mask_a_ff};
            levf_pkg::ADDR_MASK_B:   nxt_rdata = mask_b_ff;
            levf_pkg::ADDR_LIVE:     nxt_rdata = {3'h0, live_s2_ff};
            levf_pkg::ADDR_FLAGS_A:  nxt_rdata = {3'h0, flags_a};
            levf_pkg::ADDR_FLAGS_B:  nxt_rdata = flags_b;
            levf_pkg::ADDR_TALLY_LO: nxt_rdata = tally_ff[7:0];
            levf_pkg::ADDR_TALLY_HI: nxt_rdata = tally_hi_hold_ff;
            default:                 nxt_rdata = levf_pkg::RST_DATA;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o <= levf_pkg::RST_DATA;
        end else if (ce_i) begin
            rdata_o <= bus.rd ? nxt_rdata : levf_pkg::RST_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request follows unmasked flags one cycle late; drops two cycles after the clearing read strobe
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= (|(flags_a & ~mask_a_ff)) | (|(flags_b & ~mask_b_ff));
        end
    end
endmodule
`default_nettype wire

// [tb_levf_top.sv]
// testbench: event flags, clearing reads, interrupt request and error tally of the line event flag block
`timescale 1ns/1ps
`default_nettype none
module tb_levf_top;
    logic                 clk_sys_i = 1'b0;
    logic                 srst_i = 1'b1;
    logic [7:0]           addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v, w;
    logic                 wr_i = 1'b0, rd_i = 1'b0, ce_i = 1'b1, irq_o;
    levf_pkg::levf_live_s live_i = '0;
    levf_pkg::levf_evt_s  evt_i = '0;
    logic [15:0]          tally_i = 16'h0000;
    int                   n_errors = 0, checks_done = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    // clock enable driven by the bench; one scenario freezes the block
    levf_top u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .live_i(live_i), .evt_i(evt_i), .tally_i(tally_i), .rdata_o(rdata_o), .irq_o(irq_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rd(a, v);
        chk($sformatf("reg %h", a), exp, v);
    endtask
    // pulse and level changes wait out the two-flop sync and the flag update
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_sys_i);
        evt_i <= m;
        repeat (2) @(posedge clk_sys_i);
        evt_i <= '0;
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic lv(input logic [4:0] m);
        @(posedge clk_sys_i);
        live_i <= m;
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rdc(8'h19 + 8'(i), 8'h00);
        end
        rdc(8'h14, 8'h1F);
        rdc(8'h15, 8'hFF);
        // each level rises while the previous one falls: only rises count
        for (int i = 0; i < 5; i++) begin
            lv(5'(1 << i));
            rdc(8'h19, 8'(1 << i));
            rdc(8'h19, 8'h00);
        end
        lv(5'h00);
        rdc(8'h19, 8'h00);
        wr(8'h16, 8'h1F);
        rdc(8'h16, 8'h1F);
        lv(5'h1F);
        rdc(8'h19, 8'h1F);
        rdc(8'h17, 8'h1F);
        lv(5'h00);
        rdc(8'h19, 8'h1F);
        for (int i = 0; i < 8; i++) begin
            pulse(8'(1 << i));
            rdc(8'h1A, 8'(1 << i));
            rdc(8'h1A, 8'h00);
        end
        // only the tally overflow source is let through to the request
        wr(8'h15, 8'hFE);
        pulse(8'h02);
        #1 chk("irq masked", 8'h00, {7'h0, irq_o});
        pulse(8'h01);
        #1 chk("irq raised", 8'h01, {7'h0, irq_o});
        rdc(8'h19, 8'h00);
        rdc(8'h1A, 8'h03);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("irq cleared", 8'h00, {7'h0, irq_o});
        // one flags a source unmasked: its rise reaches the request too
        wr(8'h14, 8'h1E);
        lv(5'h01);
        #1 chk("irq from flags a", 8'h01, {7'h0, irq_o});
        rdc(8'h19, 8'h01);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("irq cleared a", 8'h00, {7'h0, irq_o});
        // the clearing read slides from the edge that sets the flag to four cycles after it
        for (int k = 1; k < 6; k++) begin
            @(posedge clk_sys_i);
            evt_i <= 8'h04;
            repeat (k) @(posedge clk_sys_i);
            rd(8'h1A, v);
            evt_i <= 8'h00;
            repeat (8) @(posedge clk_sys_i);
            rd(8'h1A, w);
            chk("kept event", 8'h04, v | w);
        end
        // with the enable low a read is not taken: no data and no clear
        pulse(8'h04);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        rd(8'h1A, v);
        chk("frozen read", 8'h00, v);
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        rdc(8'h1A, 8'h04);
        tally_i <= 16'h8001;
        repeat (6) @(posedge clk_sys_i);
        rdc(8'h1B, 8'h01);
        rdc(8'h1C, 8'h80);
        wr(8'h1B, 8'hFF);
        wr(8'h1C, 8'hFF);
        tally_i <= 16'h7E3C;
        repeat (6) @(posedge clk_sys_i);
        rdc(8'h1B, 8'h3C);
        rdc(8'h1C, 8'h7E);
        rdc(8'h18, 8'h00);
        rdc(8'h20, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
